// File: core/pdc_pkg.sv
// Shared constants for the loop divider control block.
// Assumes a 20 MHz system clock and a 32-bit Avalon-MM register port.
package pdc_pkg;
    // Register byte addresses
    localparam logic [7:0] ADDR_CTRL0 = 8'h38;
    localparam logic [7:0] ADDR_MRATIO = 8'h3C;
    localparam logic [7:0] ADDR_STATUS = 8'h40;

    // Control word field layout
    localparam int POST_LSB = 2;
    localparam int POST_W = 3;
    localparam int RESYNC_BIT = 1;
    localparam int PDN_BIT = 0;
    localparam int MRATIO_W = 5;
    localparam int CTRL0_W = 5;

    // Status word field layout
    localparam int STAT_EN_BIT = 0;
    localparam int STAT_BUSY_BIT = 1;
    localparam int STAT_DONE_BIT = 2;

    // Reset values
    localparam logic [2:0] POST_RST = 3'h7;
    localparam logic RESYNC_RST = 1'b1;
    localparam logic PDN_RST = 1'b0;
    localparam logic [4:0] MRATIO_RST = 5'h00;

    // Post-divider codes below this one all divide by two
    localparam logic [2:0] POST_MIN_CODE = 3'h2;
    localparam logic [3:0] POST_MIN_DIV = 4'h2;

    // Calibration time
    localparam int CLK_MHZ = 20;
    localparam int CAL_TIME_US = 10;
    localparam int CAL_CYCLES = CAL_TIME_US * CLK_MHZ;
    localparam logic [7:0] CAL_LAST = 8'(CAL_CYCLES - 1);

    typedef enum logic [1:0] {
        PDC_CAL_OFF = 2'b00,
        PDC_CAL_RUN = 2'b01,
        PDC_CAL_DONE = 2'b10
    } pdc_cal_t;
endpackage

// File: core/pdc_ratio_decode.sv
// Maps divider codes to actual divide ratios.
// Pure combinational; the caller registers the results.
`timescale 1ns/1ps
`default_nettype none
module pdc_ratio_decode (
    input wire logic [4:0] m_code,
    input wire logic [2:0] p_code,
    output logic [5:0] m_div,
    output logic m_bypass,
    output logic [3:0] p_div
);
    always_comb begin
        m_bypass = (m_code == 5'h00);
        m_div = {1'b0, m_code} + 6'h01;
        if (p_code < pdc_pkg::POST_MIN_CODE) begin
            p_div = pdc_pkg::POST_MIN_DIV;
        end else begin
            p_div = {1'b0, p_code} + 4'h1;
        end
    end
endmodule // pdc_ratio_decode
`default_nettype wire

// File: core/pdc_cal_seq.sv
// First loop enable and calibration sequencer.
// Assumes power_down comes from a register on clk_sys.
`timescale 1ns/1ps
`default_nettype none
module pdc_cal_seq (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic power_down,
    output logic loop_enable,
    output logic cal_reset,
    output logic cal_busy,
    output logic cal_done
);
    pdc_pkg::pdc_cal_t state_r;
    pdc_pkg::pdc_cal_t state_nxt;
    logic [7:0] cnt_r;
    logic [7:0] cnt_nxt;

    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        if (power_down) begin
            state_nxt = pdc_pkg::PDC_CAL_OFF;
            cnt_nxt = 8'h00;
        end else begin
            unique case (state_r)
                pdc_pkg::PDC_CAL_OFF: begin
                    state_nxt = pdc_pkg::PDC_CAL_RUN;
                    cnt_nxt = 8'h00;
                end
                pdc_pkg::PDC_CAL_RUN: begin
                    if (cnt_r == pdc_pkg::CAL_LAST) begin
                        state_nxt = pdc_pkg::PDC_CAL_DONE;
                    end else begin
                        cnt_nxt = cnt_r + 8'h01;
                    end
                end
                pdc_pkg::PDC_CAL_DONE: begin
                    state_nxt = pdc_pkg::PDC_CAL_DONE;
                end
                default: begin
                    state_nxt = pdc_pkg::PDC_CAL_OFF;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state_r <= pdc_pkg::PDC_CAL_OFF;
            cnt_r <= 8'h00;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    assign loop_enable = (state_r != pdc_pkg::PDC_CAL_OFF);
    assign cal_reset = (state_r == pdc_pkg::PDC_CAL_OFF);
    assign cal_busy = (state_r == pdc_pkg::PDC_CAL_RUN);
    assign cal_done = (state_r == pdc_pkg::PDC_CAL_DONE);

    ////////////////////////////////////////////////////////////////////////
    power_off_a: assert property (@(posedge clk_sys) disable iff (rst)
        power_down |=> !loop_enable && cal_reset)
        else $error("power down did not stop the loop");

    restart_cal_a: assert property (@(posedge clk_sys) disable iff (rst)
        $fell(power_down) && cal_reset |=> cal_busy && cnt_r == 8'h00)
        else $error("calibration did not restart from the beginning");

    cal_finish_a: assert property (@(posedge clk_sys) disable iff (rst)
        cal_busy && cnt_r == pdc_pkg::CAL_LAST && !power_down |=> cal_done && !cal_busy)
        else $error("calibration did not finish on time");

    boot_cal_a: assert property (@(posedge clk_sys) disable iff (rst)
        $past(rst) && !power_down |=> loop_enable && cal_busy)
        else $error("loop not calibrated after hardware reset");
endmodule // pdc_cal_seq
`default_nettype wire

// File: core/pdc_regs.sv
// Divider, resync and power-down control for two loops, Avalon-MM slave.
// Assumes clk_sys at 20 MHz; sync_pin_in is asynchronous to it.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Second loop M code 0 bypasses; code n divides by n+1; resets zero.
// - Post code at bits 4:2; 0,1 divide by 2, else code+1; resets 7.
// - Resync enable bit 1, reset 1, lets sync events realign first-loop outputs.
// - Power-down clear at hardware reset starts loop and calibration automatically.
// - Setting power-down disables the first loop and holds calibration in reset.
// - Clearing power-down re-enables the loop and restarts calibration from start.
module pdc_regs (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic sync_pin_in,
    output logic first_loop_enable,
    output logic first_loop_cal_reset,
    output logic first_loop_cal_busy,
    output logic first_loop_cal_done,
    output logic [3:0] first_loop_post_ratio_div,
    output logic first_loop_resync,
    output logic [5:0] second_loop_m_ratio_div,
    output logic second_loop_m_bypass
);
    ////////////////////////////////////////////////////////////////////////
    // Bus handshake

    logic ack_r;
    logic ack_nxt;
    logic req;
    logic wr_take;
    logic [31:0] readdata_r;
    logic [31:0] readdata_nxt;

    assign req = avs_read || avs_write;
    assign avs_waitrequest = req && !ack_r;
    assign wr_take = avs_write && ack_r && avs_byteenable[0];

    ////////////////////////////////////////////////////////////////////////
    // Control fields

    logic [2:0] post_r;
    logic [2:0] post_nxt;
    logic resync_en_r;
    logic resync_en_nxt;
    logic pdn_r;
    logic pdn_nxt;
    logic [4:0] m_r;
    logic [4:0] m_nxt;

    ////////////////////////////////////////////////////////////////////////
    // Sync pin and decoded outputs

    logic sync_meta_r;
    logic sync_s_r;
    logic sync_d_r;
    logic resync_r;
    logic resync_nxt;
    logic [5:0] m_div_w;
    logic m_byp_w;
    logic [3:0] p_div_w;
    logic [5:0] m_div_r;
    logic m_byp_r;
    logic [3:0] p_div_r;

    logic cal_en;
    logic cal_rst;
    logic cal_busy;
    logic cal_done;

    ////////////////////////////////////////////////////////////////////////
    // Bus next state and read mux

    always_comb begin
        ack_nxt = req && !ack_r;
        readdata_nxt = readdata_r;
        if (avs_read && !ack_r) begin
            unique case (avs_address)
                pdc_pkg::ADDR_CTRL0: begin
                    readdata_nxt = 32'h0000_0000;
                    readdata_nxt[pdc_pkg::POST_LSB +: pdc_pkg::POST_W] = post_r;
                    readdata_nxt[pdc_pkg::RESYNC_BIT] = resync_en_r;
                    readdata_nxt[pdc_pkg::PDN_BIT] = pdn_r;
                end
                pdc_pkg::ADDR_MRATIO: begin
                    readdata_nxt = {27'h0000000, m_r};
                end
                pdc_pkg::ADDR_STATUS: begin
                    readdata_nxt = 32'h0000_0000;
                    readdata_nxt[pdc_pkg::STAT_EN_BIT] = cal_en;
                    readdata_nxt[pdc_pkg::STAT_BUSY_BIT] = cal_busy;
                    readdata_nxt[pdc_pkg::STAT_DONE_BIT] = cal_done;
                end
                default: begin
                    readdata_nxt = 32'h0000_0000;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ack_r <= 1'b0;
            readdata_r <= 32'h0000_0000;
        end else begin
            ack_r <= ack_nxt;
            readdata_r <= readdata_nxt;
        end
    end

    assign avs_readdata = readdata_r;

    ////////////////////////////////////////////////////////////////////////
    // Register writes

    always_comb begin
        post_nxt = post_r;
        resync_en_nxt = resync_en_r;
        pdn_nxt = pdn_r;
        m_nxt = m_r;
        if (wr_take && avs_address == pdc_pkg::ADDR_CTRL0) begin
            // Upper bits of the byte are dropped
            post_nxt = avs_writedata[pdc_pkg::POST_LSB +: pdc_pkg::POST_W];
            resync_en_nxt = avs_writedata[pdc_pkg::RESYNC_BIT];
            pdn_nxt = avs_writedata[pdc_pkg::PDN_BIT];
        end
        if (wr_take && avs_address == pdc_pkg::ADDR_MRATIO) begin
            m_nxt = avs_writedata[pdc_pkg::MRATIO_W-1:0];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            post_r <= pdc_pkg::POST_RST;
            resync_en_r <= pdc_pkg::RESYNC_RST;
            pdn_r <= pdc_pkg::PDN_RST;
            m_r <= pdc_pkg::MRATIO_RST;
        end else begin
            post_r <= post_nxt;
            resync_en_r <= resync_en_nxt;
            pdn_r <= pdn_nxt;
            m_r <= m_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Ratio decode, registered toward the analog side

    pdc_ratio_decode u_decode (
        .m_code(m_r),
        .p_code(post_r),
        .m_div(m_div_w),
        .m_bypass(m_byp_w),
        .p_div(p_div_w)
    );

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            m_div_r <= 6'h01;
            m_byp_r <= 1'b1;
            p_div_r <= 4'h8;
        end else begin
            m_div_r <= m_div_w;
            m_byp_r <= m_byp_w;
            p_div_r <= p_div_w;
        end
    end

    assign second_loop_m_ratio_div = m_div_r;
    assign second_loop_m_bypass = m_byp_r;
    assign first_loop_post_ratio_div = p_div_r;

    ////////////////////////////////////////////////////////////////////////
    // Sync event detection

    always_comb begin
        resync_nxt = sync_s_r && !sync_d_r && resync_en_r;
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            sync_meta_r <= 1'b0;
            sync_s_r <= 1'b0;
            sync_d_r <= 1'b0;
            resync_r <= 1'b0;
        end else begin
            sync_meta_r <= sync_pin_in;
            sync_s_r <= sync_meta_r;
            sync_d_r <= sync_s_r;
            resync_r <= resync_nxt;
        end
    end

    assign first_loop_resync = resync_r;

    ////////////////////////////////////////////////////////////////////////
    // Enable and calibration sequencing

    pdc_cal_seq u_cal (
        .clk_sys(clk_sys),
        .rst(rst),
        .power_down(pdn_r),
        .loop_enable(cal_en),
        .cal_reset(cal_rst),
        .cal_busy(cal_busy),
        .cal_done(cal_done)
    );

    assign first_loop_enable = cal_en;
    assign first_loop_cal_reset = cal_rst;
    assign first_loop_cal_busy = cal_busy;
    assign first_loop_cal_done = cal_done;

    ////////////////////////////////////////////////////////////////////////
    // Checks

    m_ratio_decode_a: assert property (@(posedge clk_sys) disable iff (rst)
        !$past(rst) |-> second_loop_m_ratio_div == {1'b0, $past(m_r)} + 6'h01
            && second_loop_m_bypass == ($past(m_r) == 5'h00))
        else $error("second loop ratio wrong");

    post_decode_a: assert property (@(posedge clk_sys) disable iff (rst)
        !$past(rst) |-> first_loop_post_ratio_div ==
            (($past(post_r) < 3'h2) ? 4'h2 : {1'b0, $past(post_r)} + 4'h1))
        else $error("post ratio wrong");

    resync_pulse_a: assert property (@(posedge clk_sys) disable iff (rst)
        sync_s_r && !sync_d_r |=> first_loop_resync == $past(resync_en_r) ##1 !first_loop_resync)
        else $error("resync pulse wrong");

    pdn_write_a: assert property (@(posedge clk_sys) disable iff (rst)
        wr_take && avs_address == pdc_pkg::ADDR_CTRL0 && avs_writedata[pdc_pkg::PDN_BIT]
            |-> ##2 !first_loop_enable)
        else $error("loop still enabled after power down write");

    reserved_zero_a: assert property (@(posedge clk_sys) disable iff (rst)
        avs_read && !avs_waitrequest |-> avs_readdata[31:5] == 27'h0)
        else $error("reserved bits not zero");

    bus_answer_a: assert property (@(posedge clk_sys) disable iff (rst)
        req && avs_waitrequest && $stable(avs_address) |=> !avs_waitrequest || !req)
        else $error("waitrequest held too long");

    ////////////////////////////////////////////////////////////////////////
    // Bus handshake, bus map, resync-disable and reset checks

    ack_release_a: assert property (@(posedge clk_sys) disable iff (rst)
        ack_r |=> !ack_r)
        else $error("bus answer held for more than one cycle");

    ctrl_read_a: assert property (@(posedge clk_sys) disable iff (rst)
        avs_read && !avs_waitrequest && avs_address == pdc_pkg::ADDR_CTRL0
            |-> avs_readdata[pdc_pkg::POST_LSB +: pdc_pkg::POST_W] == post_r
            && avs_readdata[pdc_pkg::RESYNC_BIT] == resync_en_r
            && avs_readdata[pdc_pkg::PDN_BIT] == pdn_r)
        else $error("control word read back wrong");

    mratio_read_a: assert property (@(posedge clk_sys) disable iff (rst)
        avs_read && !avs_waitrequest && avs_address == pdc_pkg::ADDR_MRATIO
            |-> avs_readdata[pdc_pkg::MRATIO_W-1:0] == m_r)
        else $error("ratio word read back wrong");

    unmapped_read_a: assert property (@(posedge clk_sys) disable iff (rst)
        avs_read && !avs_waitrequest && avs_address != pdc_pkg::ADDR_CTRL0
            && avs_address != pdc_pkg::ADDR_MRATIO && avs_address != pdc_pkg::ADDR_STATUS
            |-> avs_readdata == 32'h0000_0000)
        else $error("unmapped address read not zero");

    ctrl_write_a: assert property (@(posedge clk_sys) disable iff (rst)
        wr_take && avs_address == pdc_pkg::ADDR_CTRL0
            |=> post_r == $past(avs_writedata[pdc_pkg::POST_LSB +: pdc_pkg::POST_W])
            && resync_en_r == $past(avs_writedata[pdc_pkg::RESYNC_BIT])
            && pdn_r == $past(avs_writedata[pdc_pkg::PDN_BIT]))
        else $error("control write did not land");

    mratio_write_a: assert property (@(posedge clk_sys) disable iff (rst)
        wr_take && avs_address == pdc_pkg::ADDR_MRATIO
            |=> m_r == $past(avs_writedata[pdc_pkg::MRATIO_W-1:0]))
        else $error("ratio write did not land");

    write_drop_a: assert property (@(posedge clk_sys) disable iff (rst)
        avs_write && ack_r && (!avs_byteenable[0] || (avs_address != pdc_pkg::ADDR_CTRL0
            && avs_address != pdc_pkg::ADDR_MRATIO))
            |=> $stable({post_r, resync_en_r, pdn_r, m_r}))
        else $error("dropped write changed a register");

    resync_off_a: assert property (@(posedge clk_sys) disable iff (rst)
        !resync_en_r |=> !first_loop_resync)
        else $error("resync pulse while disabled");

    reset_value_a: assert property (@(posedge clk_sys)
        rst |=> !first_loop_enable && first_loop_cal_reset && second_loop_m_bypass
            && first_loop_post_ratio_div == 4'h8 && avs_readdata == 32'h0000_0000)
        else $error("outputs wrong after reset");
endmodule // pdc_regs
`default_nettype wire

// File: verif/pdc_regs_tb.sv
// Self-checking bench for pdc_regs: ratios, resync, power-down, bus map.
// Assumes pdc_pkg constants; each bus answer is awaited for up to 20 cycles, then flagged.
`timescale 1ns/1ps
`default_nettype none
module pdc_regs_tb;
    logic clk_sys, rst, avs_read, avs_write, sync_pin_in;
    logic [7:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, q;
    logic [3:0] avs_byteenable, post_div;
    logic avs_waitrequest, en, cal_rst, busy, done, resync, byp;
    logic [5:0] m_div;
    int errors, checks_done, n;

    pdc_regs dut (.clk_sys(clk_sys), .rst(rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .sync_pin_in(sync_pin_in),
        .first_loop_enable(en), .first_loop_cal_reset(cal_rst),
        .first_loop_cal_busy(busy), .first_loop_cal_done(done),
        .first_loop_post_ratio_div(post_div), .first_loop_resync(resync),
        .second_loop_m_ratio_div(m_div), .second_loop_m_bypass(byp));

    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic give_verdict();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    // One Avalon access; waitrequest and read data taken at the rising edge
    task automatic access(input logic wr, input logic [7:0] a, input logic [31:0] d,
            input logic [3:0] be);
        int k;
        k = 0;
        @(posedge clk_sys);
        avs_address <= a;
        avs_writedata <= d;
        avs_byteenable <= be;
        avs_read <= !wr;
        avs_write <= wr;
        @(posedge clk_sys);
        k = 1;
        while (avs_waitrequest !== 1'b0 && k < 20) begin
            @(posedge clk_sys);
            k++;
        end
        if (avs_waitrequest !== 1'b0) chk("waitrequest", 0, 1);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
        access(1'b0, a, 32'h0, 4'h0);
        chk(what, exp, q);
    endtask

    task automatic settle();
        repeat (3) @(negedge clk_sys);
    endtask

    // Cycles from now until calibration reports done
    task automatic wait_done();
        n = 0;
        while (done !== 1'b1 && n < 400) begin
            @(negedge clk_sys);
            n++;
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        repeat (2) @(negedge clk_sys);
        chk("enable", 1, en);
        chk("busy", 1, busy);
        chk("cal_reset", 0, cal_rst);
        chk("post_div", 8, post_div);
        chk("m_bypass", 1, byp);
        wait_done();
        chk("cal_len_rst", 1, n >= 197 && n <= 201);
        rd(pdc_pkg::ADDR_CTRL0, 32'h1E, "ctrl0_rst");
        rd(pdc_pkg::ADDR_MRATIO, 32'h0, "mratio_rst");
        rd(pdc_pkg::ADDR_STATUS, 32'h5, "status_done");
    endtask

    task automatic t_mratio();
        logic [4:0] codes [4] = '{5'h00, 5'h01, 5'h1E, 5'h1F};
        foreach (codes[i]) begin
            access(1'b1, pdc_pkg::ADDR_MRATIO, 32'hFFFFFFE0 | codes[i], 4'hF);
            settle();
            rd(pdc_pkg::ADDR_MRATIO, {27'h0, codes[i]}, "mratio_rb");
            chk("m_div", codes[i] == 0 ? 1 : codes[i] + 1, m_div);
            chk("m_bypass", codes[i] == 0, byp);
        end
    endtask

    task automatic t_post();
        for (int c = 0; c < 8; c++) begin
            access(1'b1, pdc_pkg::ADDR_CTRL0, 32'(c * 4 + 2), 4'hF);
            settle();
            chk("post_div", c < 2 ? 2 : c + 1, post_div);
        end
    endtask

    task automatic count_sync(input logic ena, input int exp);
        int k;
        k = 0;
        access(1'b1, pdc_pkg::ADDR_CTRL0, {30'h7, ena, 1'b0}, 4'hF);
        settle();
        @(posedge clk_sys);
        sync_pin_in <= 1'b1;
        repeat (10) begin
            @(negedge clk_sys);
            if (resync === 1'b1) k++;
        end
        @(posedge clk_sys);
        sync_pin_in <= 1'b0;
        repeat (4) @(posedge clk_sys);
        chk("resync_pulses", exp, k);
    endtask

    task automatic t_pdn();
        access(1'b1, pdc_pkg::ADDR_CTRL0, 32'h1F, 4'hF);
        settle();
        chk("pdn_enable", 0, en);
        chk("pdn_cal_reset", 1, cal_rst);
        chk("pdn_done", 0, done);
        rd(pdc_pkg::ADDR_STATUS, 32'h0, "status_pdn");
        access(1'b1, pdc_pkg::ADDR_CTRL0, 32'h1E, 4'hF);
        settle();
        chk("up_enable", 1, en);
        chk("up_busy", 1, busy);
        chk("up_cal_reset", 0, cal_rst);
        repeat (100) @(negedge clk_sys);
        access(1'b1, pdc_pkg::ADDR_CTRL0, 32'h1F, 4'hF);
        settle();
        chk("abort_busy", 0, busy);
        access(1'b1, pdc_pkg::ADDR_CTRL0, 32'h1E, 4'hF);
        wait_done();
        chk("cal_len_restart", 1, n >= 200 && n <= 204);
        chk("cal_busy_end", 0, busy);
    endtask

    task automatic t_misc();
        rd(8'h44, 32'h0, "unmapped");
        access(1'b1, pdc_pkg::ADDR_CTRL0, 32'h0, 4'hE);
        rd(pdc_pkg::ADDR_CTRL0, 32'h1E, "lane0_off");
        access(1'b1, pdc_pkg::ADDR_CTRL0, 32'hFFFFFFFE, 4'hF);
        rd(pdc_pkg::ADDR_CTRL0, 32'h1E, "reserved_bits");
        access(1'b1, pdc_pkg::ADDR_STATUS, 32'h0, 4'hF);
        rd(pdc_pkg::ADDR_STATUS, 32'h5, "status_ro");
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (5000) @(posedge clk_sys);
        errors++;
        $display("CHECK FAILED watchdog expected finish seen timeout");
        give_verdict();
    end

    initial begin
        errors = 0;
        checks_done = 0;
        rst = 1'b1;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_address = 8'h00;
        avs_writedata = 32'h0;
        avs_byteenable = 4'h0;
        sync_pin_in = 1'b0;
        repeat (3) @(posedge clk_sys);
        rst <= 1'b0;
        t_reset();
        t_mratio();
        t_post();
        count_sync(1'b1, 1);
        count_sync(1'b0, 0);
        t_pdn();
        t_misc();
        give_verdict();
    end
endmodule // pdc_regs_tb
`default_nettype wire
